/* rtl/msp_port_mux.sv */
// Purpose: Per-port function selection for a 20-port mixed-signal I/O block
// Assumes: Comparator outputs arrive asynchronously on port_sense_i
// Notes:   Analog settling is done by the front end; this logic holds the controls
`timescale 1ns/1ps
`include "msp_map.svh"

// Contract
// [RULE1] Code 3 drives output state bit, converter high
// [RULE2] Software loads level, waits 1ms first
// [RULE3] Code 4 copies associated port's sensed state
// [RULE4] Invert flag complements path output
// [RULE5] Many path outputs may share one input
// [RULE6] Software configures source input before path output
// [RULE7] Code 5 drives analog converter value
// [RULE8] Analog output accepts range codes 1 to 3
// [RULE9] Software limits data for 2.5V ranges
// [RULE10] Code 6 converter output with monitoring
// [RULE11] Code 7 single-ended input with averaging
// [RULE12] Code 8 differential positive, names negative port
// [RULE13] Code 9 differential negative input
// [RULE14] Code 10 output plus pseudo-differential negative
// [RULE15] Software configures associated ports compatibly
// [RULE16] Word: code 15:12, parameter 11:0
// [RULE17] Code 0 is high impedance
// [RULE18] Code 1 threshold digital input
// [RULE19] Code 2 translator with next port
// [RULE20] Codes 13 to 15 behave as high impedance
module msp_port_mux #(
   parameter int NPORTS = `MSP_NUM_PORTS
) (
   input  wire logic                    core_clk_i,
   input  wire logic                    reset_i,
   input  wire logic [`MSP_ADDR_W-1:0]  avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   input  wire logic [3:0]              avs_byteenable_i,
   output logic      [31:0]             avs_readdata_o,
   output logic                         avs_waitrequest_o,
   output logic      [1:0]              avs_response_o,
   input  wire logic [NPORTS-1:0]       port_sense_i,
   output msp_pkg::msp_ctl_t            port_ctl_o [NPORTS],
   output logic      [NPORTS-1:0]       config_error_o
);
   import msp_pkg::*;

   msp_cfg_t          cfg_reg [NPORTS];
   logic [11:0]       dac_reg [NPORTS];
   logic [NPORTS-1:0] output_state_bits_reg;
   logic [NPORTS-1:0] sense_meta_reg;
   logic [NPORTS-1:0] sense_reg;
   logic              wait_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        resp_reg;
   msp_ctl_t          ctl_next [NPORTS];
   logic [NPORTS-1:0] err_next;

   // Bus decode
   wire       req      = (avs_read_i | avs_write_i) & wait_reg;
   wire       in_cfg   = avs_address_i < (`MSP_CFG_BASE + NPORTS[`MSP_ADDR_W-1:0]);
   wire       in_dac   = (avs_address_i >= `MSP_DAC_BASE)
                       & (avs_address_i < (`MSP_DAC_BASE + NPORTS[`MSP_ADDR_W-1:0]));
   wire [4:0] cfg_idx  = 5'(avs_address_i - `MSP_CFG_BASE);
   wire [4:0] dac_idx  = 5'(avs_address_i - `MSP_DAC_BASE);
   wire       is_out   = avs_address_i == `MSP_OUT_ADDR;
   wire       is_in    = avs_address_i == `MSP_IN_ADDR;
   wire       is_err   = avs_address_i == `MSP_ERR_ADDR;
   wire       mapped   = in_cfg | in_dac | is_out | is_in | is_err;
   wire       wr_go    = req & avs_write_i;
   wire [15:0] wmask   = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire [31:0] wmask32 = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}}, wmask};

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_cfg) begin
         rd_mux[15:0] = cfg_reg[cfg_idx];
      end else if (in_dac) begin
         rd_mux[11:0] = dac_reg[dac_idx];
      end else if (is_out) begin
         rd_mux[NPORTS-1:0] = output_state_bits_reg;
      end else if (is_in) begin
         rd_mux[NPORTS-1:0] = sense_reg;
      end else if (is_err) begin
         rd_mux[NPORTS-1:0] = config_error_o;
      end
   end

   // One wait state: answer on the edge after the request is seen
   // Waitrequest has its own flop so the pin carries no gate
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         resp_reg  <= 2'h0;
      end else begin
         wait_reg  <= ~req;
         rdata_reg <= (req & avs_read_i) ? rd_mux : 32'h0000_0000;
         resp_reg  <= (req & ~mapped) ? 2'h2 : 2'h0;
      end
   end

   assign avs_waitrequest_o = wait_reg;
   assign avs_readdata_o    = rdata_reg;
   assign avs_response_o    = resp_reg;

   // Register file
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < NPORTS; i++) begin
            cfg_reg[i] <= `MSP_CFG_RESET;
            dac_reg[i] <= `MSP_DAC_RESET;
         end
         output_state_bits_reg <= '0;
      end else if (wr_go) begin
         if (in_cfg) begin
            cfg_reg[cfg_idx] <= (cfg_reg[cfg_idx] & ~wmask)
                              | (avs_writedata_i[15:0] & wmask); // [RULE16]
         end
         if (in_dac) begin
            dac_reg[dac_idx] <= (dac_reg[dac_idx] & ~wmask[11:0])
                              | (avs_writedata_i[11:0] & wmask[11:0]);
         end
         if (is_out) begin
            output_state_bits_reg <= (output_state_bits_reg & ~wmask32[NPORTS-1:0])
                                   | (avs_writedata_i[NPORTS-1:0] & wmask32[NPORTS-1:0]);
         end
      end
   end

   // Comparator results cross in from the analog side
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sense_meta_reg <= '0;
         sense_reg      <= '0;
      end else begin
         sense_meta_reg <= port_sense_i;
         sense_reg      <= sense_meta_reg;
      end
   end

   // Function decode per port
   always_comb begin
      for (int i = 0; i < NPORTS; i++) begin
         logic [3:0]  fc;
         logic [11:0] pr;
         logic [4:0]  asc;
         logic        src;
         fc  = cfg_reg[i].port_function_code;
         pr  = cfg_reg[i].port_function_param;
         asc = pr[`MSP_ASC_HI:`MSP_ASC_LO];
         // Any number of ports may read the same source
         src = (asc < NPORTS[4:0]) ? sense_reg[asc] : 1'b0; // [RULE5]
         ctl_next[i] = '0;
         err_next[i] = 1'b0;
         ctl_next[i].level                   = dac_reg[i];
         ctl_next[i].range                   = pr[`MSP_RNG_HI:`MSP_RNG_LO];
         ctl_next[i].sample_reference_select = pr[`MSP_INV_BIT];
         unique case (fc)
            MSP_FN_HIZ: begin
               ctl_next[i] = '0; // [RULE17]
            end
            MSP_FN_THR_IN: begin
               ctl_next[i].thr_in = 1'b1; // [RULE18]
            end
            MSP_FN_XLATE: begin
               // Last port has no upper neighbour; neighbour must be idle
               if (i == NPORTS - 1) begin
                  err_next[i] = 1'b1; // [RULE19]
               end else begin
                  ctl_next[i].xlate_en = 1'b1; // [RULE19]
                  ctl_next[i].thr_in   = 1'b1;
                  err_next[i] = cfg_reg[(i + 1) % NPORTS].port_function_code != MSP_FN_HIZ;
               end
            end
            MSP_FN_REG_OUT: begin
               ctl_next[i].dig_oe  = 1'b1; // [RULE1]
               ctl_next[i].dig_val = output_state_bits_reg[i]; // [RULE1]
            end
            MSP_FN_PATH_OUT: begin
               ctl_next[i].dig_oe  = 1'b1; // [RULE3]
               ctl_next[i].dig_val = src ^ pr[`MSP_INV_BIT]; // [RULE4]
               ctl_next[i].pair_port = asc;
               ctl_next[i].sample_reference_select = 1'b0;
               err_next[i] = asc >= NPORTS[4:0];
            end
            MSP_FN_AOUT: begin
               ctl_next[i].aout_en = 1'b1; // [RULE7]
               ctl_next[i].sample_reference_select = 1'b0;
               // Bad range leaves the output off rather than guess a span
               if (pr[`MSP_RNG_HI:`MSP_RNG_LO] == 3'h0 || pr[`MSP_RNG_HI:`MSP_RNG_LO] > 3'h3) begin
                  ctl_next[i].aout_en = 1'b0; // [RULE8]
                  err_next[i] = 1'b1; // [RULE8]
               end
            end
            MSP_FN_AOUT_MON: begin
               ctl_next[i].aout_en   = 1'b1; // [RULE10]
               ctl_next[i].sample_en = 1'b1; // [RULE10]
            end
            MSP_FN_SE_IN: begin
               ctl_next[i].sample_en = 1'b1; // [RULE11]
               ctl_next[i].samples   = pr[`MSP_SMP_HI:`MSP_SMP_LO]; // [RULE11]
            end
            MSP_FN_DIFF_P: begin
               ctl_next[i].sample_en = 1'b1; // [RULE12]
               ctl_next[i].samples   = pr[`MSP_SMP_HI:`MSP_SMP_LO];
               ctl_next[i].pair_port = asc; // [RULE12]
               err_next[i] = asc >= NPORTS[4:0];
            end
            MSP_FN_DIFF_N: begin
               ctl_next[i].sample_en = 1'b1; // [RULE13]
               ctl_next[i].diff_neg  = 1'b1; // [RULE13]
            end
            MSP_FN_PSD_N: begin
               ctl_next[i].aout_en   = 1'b1; // [RULE14]
               ctl_next[i].sample_en = 1'b1;
               ctl_next[i].diff_neg  = 1'b1; // [RULE14]
            end
            MSP_FN_SW_GPI, MSP_FN_SW_REG: begin
               // Analog switch handled by the switch block; no drive here
               ctl_next[i] = '0;
            end
            default: begin
               ctl_next[i] = '0; // [RULE20]
               err_next[i] = 1'b1; // [RULE20]
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < NPORTS; i++) begin
            port_ctl_o[i] <= '0;
         end
         config_error_o <= '0;
      end else begin
         port_ctl_o     <= ctl_next;
         config_error_o <= err_next;
      end
   end

endmodule

/* inc/msp_map.svh */
// Purpose: Register offsets, field positions and timing constants for the port mux
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes:   Included by the package and the design file
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
`define MSP_NUM_PORTS      20
`define MSP_ADDR_W         7
`define MSP_CFG_BASE       7'h00
`define MSP_DAC_BASE       7'h20
`define MSP_OUT_ADDR       7'h40
`define MSP_IN_ADDR        7'h41
`define MSP_ERR_ADDR       7'h42
`define MSP_FC_HI          15
`define MSP_FC_LO          12
`define MSP_INV_BIT        11
`define MSP_RNG_HI         10
`define MSP_RNG_LO         8
`define MSP_SMP_HI         7
`define MSP_SMP_LO         5
`define MSP_ASC_HI         4
`define MSP_ASC_LO         0
`define MSP_CFG_RESET      16'h0000
`define MSP_DAC_RESET      12'h000
`define MSP_SETTLE_MS      1
`define MSP_CLK_KHZ        40000
`endif

/* inc/msp_pkg.sv */
// Purpose: Types for the mixed-signal port function mux
// Assumes: msp_map.svh constants
// Notes:   Function codes follow the configuration word encoding
package msp_pkg;
`include "msp_map.svh"
   typedef enum logic [3:0] {
      MSP_FN_HIZ      = 4'h0,
      MSP_FN_THR_IN   = 4'h1,
      MSP_FN_XLATE    = 4'h2,
      MSP_FN_REG_OUT  = 4'h3,
      MSP_FN_PATH_OUT = 4'h4,
      MSP_FN_AOUT     = 4'h5,
      MSP_FN_AOUT_MON = 4'h6,
      MSP_FN_SE_IN    = 4'h7,
      MSP_FN_DIFF_P   = 4'h8,
      MSP_FN_DIFF_N   = 4'h9,
      MSP_FN_PSD_N    = 4'hA,
      MSP_FN_SW_GPI   = 4'hB,
      MSP_FN_SW_REG   = 4'hC
   } msp_func_t;

   typedef struct packed {
      logic [3:0]  port_function_code;
      logic [11:0] port_function_param;
   } msp_cfg_t;

   // Per-port drive request presented to the analog front end
   typedef struct packed {
      logic        dig_oe;       // Digital output driven
      logic        dig_val;      // Digital output level
      logic        aout_en;      // Converter output enabled
      logic        sample_en;    // Port sampled by the converter
      logic        diff_neg;     // Port is a negative sampling input
      logic        thr_in;       // Threshold comparator enabled
      logic        xlate_en;     // Level translator to next port
      logic        sample_reference_select;
      logic [2:0]  range;
      logic [2:0]  samples;
      logic [4:0]  pair_port;
      logic [11:0] level;        // Converter value: high level, threshold or voltage
   } msp_ctl_t;
endpackage

/* verification/msp_port_mux_props.sv */
// Purpose: Bus answer and port 0 control checks for the port mux
// Assumes: Port 0 word mirrored from accepted bus writes
// Notes:   Controls trail the register by one edge
`timescale 1ns/1ps
`include "msp_map.svh"
module msp_port_mux_props #(
   parameter int NPORTS = 20
) (
   input wire logic                   core_clk_i,
   input wire logic                   reset_i,
   input wire logic [`MSP_ADDR_W-1:0] avs_address_i,
   input wire logic                   avs_read_i,
   input wire logic                   avs_write_i,
   input wire logic [31:0]            avs_writedata_i,
   input wire logic [3:0]             avs_byteenable_i,
   input wire logic                   avs_waitrequest_o,
   input wire logic [1:0]             avs_response_o,
   input wire msp_pkg::msp_ctl_t      port_ctl_o [NPORTS],
   input wire logic [NPORTS-1:0]      config_error_o
);
   import msp_pkg::*;

   logic [15:0] cfg_reg;
   logic [15:0] cfg_d;
   // Writes land at the taking edge, while waitrequest is still high
   wire         take0  = avs_write_i && avs_waitrequest_o && avs_address_i == 7'h00;
   wire  [6:0]  a      = avs_address_i;
   wire         mapped = a < 7'h14 || (a >= 7'h20 && a < 7'h34) || (a >= 7'h40 && a < 7'h43);
   wire  [3:0]  fc     = cfg_d[15:12];
   wire  [2:0]  rng    = cfg_d[10:8];
   msp_ctl_t    c0;
   assign c0 = port_ctl_o[0];
   wire quiet0 = !(c0.dig_oe | c0.aout_en | c0.sample_en | c0.thr_in | c0.xlate_en);
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         cfg_reg <= 16'h0000;
         cfg_d   <= 16'h0000;
      end else begin
         if (take0 && avs_byteenable_i[0]) cfg_reg[7:0] <= avs_writedata_i[7:0];
         if (take0 && avs_byteenable_i[1]) cfg_reg[15:8] <= avs_writedata_i[15:8];
         cfg_d <= cfg_reg;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_taken;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_req_answered: assert property (s_taken |=> s_answer)
      else $error("late bus answer");
   a_unmapped_resp: assert property (!avs_waitrequest_o |->
      avs_response_o == (mapped ? 2'b00 : 2'b10)) else $error("bad response code");
   a_hiz_quiet: assert property (fc == 4'h0 |-> quiet0) else $error("code 0 drives");
   a_undef_quiet: assert property (fc > 4'hC |-> quiet0 && config_error_o[0])
      else $error("undefined code drives");
   a_reg_out_oe: assert property (fc == 4'h3 |-> c0.dig_oe && !c0.aout_en)
      else $error("code 3 not driving");
   a_thr_input: assert property (fc == 4'h1 |-> c0.thr_in && !c0.dig_oe)
      else $error("code 1 not input");
   a_aout_range: assert property (fc == 4'h5 |->
      c0.aout_en == (rng != 3'h0 && rng < 3'h4)) else $error("analog range gate wrong");
   a_field_split: assert property (fc == 4'h7 |-> c0.range == rng
      && c0.samples == cfg_d[7:5] && c0.sample_reference_select == cfg_d[11])
      else $error("field split wrong");
   a_diff_neg: assert property (fc == 4'h9 |-> c0.diff_neg && !c0.aout_en)
      else $error("code 9 not negative");
   a_pseudo_diff: assert property (fc == 4'hA |-> c0.diff_neg && c0.aout_en)
      else $error("code 10 wrong");
endmodule
bind msp_port_mux msp_port_mux_props #(.NPORTS(NPORTS)) u_props (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
   .avs_response_o(avs_response_o), .port_ctl_o(port_ctl_o), .config_error_o(config_error_o));

/* verification/msp_port_mux_test.sv */
// Purpose: Directed register-bus tests of the port mux
// Assumes: Controls sampled two edges after a configuration write
// Notes:   Only fields each code defines are compared
`timescale 1ns/1ps
`include "msp_map.svh"
module msp_port_mux_test;
   import msp_pkg::*;
   logic        core_clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [6:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic [3:0]  avs_byteenable_i;
   logic [1:0]  avs_response_o, r;
   logic [19:0] port_sense_i, config_error_o;
   msp_ctl_t    port_ctl_o [20];
   int          n_fail = 0, total_checks = 0, cyc = 0;
   msp_port_mux u_msp_port_mux (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .avs_response_o(avs_response_o), .port_sense_i(port_sense_i),
      .port_ctl_o(port_ctl_o), .config_error_o(config_error_o));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic print_verdict;
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Hang guard above the settling wait plus the directed sequence
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 50000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      @(posedge core_clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
      q = avs_readdata_o;
      r = avs_response_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic cfg(input int p, input logic [3:0] c, input logic [11:0] prm);
      bus(1'b1, 7'(p), {16'h0000, c, prm});
      repeat (2) @(posedge core_clk_i);
   endtask
   initial begin
      reset_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 7'h00;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hF;
      port_sense_i = 20'h0;
      repeat (6) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      bus(1'b0, 7'h00, 32'h0);
      chk(q, 32'h0);
      chk(port_ctl_o[0].dig_oe, 1'b0);
      bus(1'b0, 7'h55, 32'h0);
      chk({q[29:0], r}, 32'h2);
      for (int c = 0; c < 16; c++) begin
         cfg(0, c[3:0], 12'h100);
         bus(1'b0, 7'h00, 32'h0);
         chk(q, {16'h0000, c[3:0], 12'h100});
         chk(port_ctl_o[0].dig_oe, c inside {3, 4});
         chk(port_ctl_o[0].aout_en, c inside {5, 6, 10});
         chk(port_ctl_o[0].diff_neg, c inside {9, 10});
         chk(config_error_o[0], c > 12);
         if (c != 2) chk(port_ctl_o[0].thr_in, c == 1);
         if (c == 2) chk(port_ctl_o[0].xlate_en, 1'b1);
         if (c < 9 || c > 10) chk(port_ctl_o[0].sample_en, c inside {6, 7, 8});
      end
      // High level loaded and given time to settle before the output mode
      bus(1'b1, 7'h20, 32'hABC);
      bus(1'b0, 7'h20, 32'h0);
      chk(q, 32'hABC);
      repeat (`MSP_SETTLE_MS * `MSP_CLK_KHZ) @(posedge core_clk_i);
      bus(1'b1, 7'h40, 32'h1);
      cfg(0, 4'h3, 12'h000);
      chk(port_ctl_o[0].level, 12'hABC);
      chk(port_ctl_o[0].dig_val, 1'b1);
      bus(1'b1, 7'h40, 32'h0);
      @(posedge core_clk_i);
      chk(port_ctl_o[0].dig_val, 1'b0);
      // Two path outputs share port 1, the second inverted
      cfg(1, 4'h1, 12'h000);
      cfg(2, 4'h4, 12'h001);
      cfg(3, 4'h4, 12'h801);
      for (int s = 0; s < 2; s++) begin
         port_sense_i <= 20'(s << 1);
         repeat (5) @(posedge core_clk_i);
         chk(port_ctl_o[2].dig_val, s);
         chk(port_ctl_o[3].dig_val, !s);
         chk(port_ctl_o[2].dig_val ^ port_ctl_o[3].dig_val, 1'b1);
      end
      bus(1'b0, 7'h41, 32'h0);
      chk(q, 32'h2);
      // Port 4 converter data stays at zero, inside the low span
      for (int g = 0; g < 8; g++) begin
         cfg(4, 4'h5, {1'b0, g[2:0], 8'h00});
         chk({port_ctl_o[4].aout_en, config_error_o[4]}, g inside {1, 2, 3} ? 2 : 1);
      end
      cfg(7, 4'h9, 12'h000);
      chk(port_ctl_o[7].diff_neg, 1'b1);
      cfg(5, 4'h8, {1'b1, 3'd3, 3'd5, 5'd7});
      chk({port_ctl_o[5].sample_reference_select, port_ctl_o[5].range,
           port_ctl_o[5].samples, port_ctl_o[5].pair_port}, {1'b1, 3'd3, 3'd5, 5'd7});
      cfg(19, 4'h2, 12'h000);
      chk(config_error_o[19], 1'b1);
      cfg(6, 4'h4, 12'h014);
      chk(config_error_o[6], 1'b1);
      cfg(7, 4'h2, 12'h000);
      cfg(8, 4'h1, 12'h000);
      chk(config_error_o[7], 1'b1);
      cfg(8, 4'h0, 12'h000);
      chk(config_error_o[7], 1'b0);
      print_verdict();
   end
endmodule
